// ### src/afe_ctrl_consts.svh
// afe_ctrl_consts.svh: offsets, field positions, reset values and timing
// figures for the front-end control block; definitions only
`ifndef AFE_CTRL_CONSTS_SVH
`define AFE_CTRL_CONSTS_SVH

// system clock period
`define REF_CLK_PERIOD_NS 4
// recovery times, as printed
`define T_FAST_NS 500
`define T_SLOW_RX2TX_NS 7000
`define T_SLOW_TX2RX_NS 8100

// serial command layout: address nibble above a 12-bit data field
`define CMD_BITS 5'h10
`define CMD_ADDR_MSB 15
`define CMD_ADDR_LSB 12
`define CMD_DATA_MSB 11
`define SRC_SEL_BIT 3
`define AUX_FIELD_MSB 10

// command addresses
`define ADDR_ENABLE16 4'h0
`define ADDR_ENABLE8 4'h8
`define ADDR_FREQ_DAC 4'h1
`define ADDR_GAIN_DAC_A 4'h2
`define ADDR_GAIN_DAC_B 4'h3
`define ADDR_AUX_MODE 4'h9

// power/mode codes in the low three bits of the enable words
`define MODE_SHUTDOWN_STATE 3'h0
`define MODE_IDLE 3'h1
`define MODE_STANDBY_STATE 3'h2
`define MODE_SLOW_TX 3'h4
`define MODE_FAST_RX 3'h5
`define MODE_FAST_TX 3'h6

// reset values
`define AUX_CTRL_RST 11'h000
`define FREQ_DAC_RST 12'h6E0
`define GAIN_DAC_RST 12'h000

// conversion: edge 0 samples, edge 11 loads the result
`define CONV_LAST_EDGE 4'hB

`endif

// ### src/afe_ctrl_pkg.sv
// afe_ctrl_pkg: types and small helpers shared by the control block
// and its aux converter sequencer
package afe_ctrl_pkg;

  // tx/rx power state, one-hot
  typedef enum logic [4:0] {
    ST_SHUTDOWN_STATE = 5'h01,
    ST_IDLE = 5'h02,
    ST_STANDBY_STATE = 5'h04,
    ST_RX = 5'h08,
    ST_TX = 5'h10
  } txrx_state_t;

  // serial data output behaviour, one-hot
  typedef enum logic [3:0] {
    DO_FLOAT = 4'h1,
    DO_BUSY = 4'h2,
    DO_READY = 4'h4,
    DO_SHIFT = 4'h8
  } dout_state_t;

  // aux converter control word, bit 10 down to bit 0
  typedef struct packed {
    logic aux_readout_enable;
    logic [2:0] aux_clock_divide;
    logic [2:0] aux_average_select;
    logic [1:0] aux_input_select;
    logic aux_ref_select;
    logic aux_convert_start;
  } aux_ctrl_t;

  // log2 of the averaging count; 11x behaves as 101
  function automatic logic [2:0] avg_shift(input logic [2:0] code);
    return (code > 3'h5) ? 3'h5 : code;
  endfunction

  // terminal count of the clock divider (divisor minus one)
  function automatic logic [6:0] div_limit(input logic [2:0] code);
    return 7'((8'h01 << code) - 8'h01);
  endfunction

endpackage

// ### src/aux_adc_seq.sv
// aux_adc_seq: conversion sequencer with divider and averaging
// assumes sample_in is a code from the analog core on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_consts.svh"
module aux_adc_seq
  import afe_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire aux_ctrl_t cfg,
  input wire logic [9:0] sample_in,
  output logic sample_take,
  output logic busy,
  output logic done,
  output logic [9:0] result
);
  aux_ctrl_t cfg_ff; // settings frozen at start
  logic busy_ff, done_ff;
  logic [6:0] div_cnt_ff; // conversion clock divider
  logic [3:0] edge_ff; // edge within one conversion
  logic [5:0] conv_ff; // conversions finished
  logic [14:0] acc_ff; // sum of up to 32 codes
  logic [9:0] smp_ff, result_ff;
  logic tick, last_conv;
  logic [14:0] sum;

  assign tick = busy_ff && (div_cnt_ff == div_limit(cfg_ff.aux_clock_divide));
  assign sum = 15'(acc_ff + {5'h00, smp_ff});
  assign last_conv = (6'(conv_ff + 6'h01) ==
                      6'(7'h01 << avg_shift(cfg_ff.aux_average_select)));
  assign sample_take = tick && (edge_ff == 4'h0);
  assign busy = busy_ff;
  assign done = done_ff;
  assign result = result_ff;

  // divider, edge count, averaging; start while busy is ignored
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= aux_ctrl_t'(`AUX_CTRL_RST);
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      div_cnt_ff <= 7'h00;
      edge_ff <= 4'h0;
      conv_ff <= 6'h00;
      acc_ff <= 15'h0000;
      smp_ff <= 10'h000;
      result_ff <= 10'h000;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        cfg_ff <= cfg;
        busy_ff <= 1'b1;
        div_cnt_ff <= 7'h00;
        edge_ff <= 4'h0;
        conv_ff <= 6'h00;
        acc_ff <= 15'h0000;
      end else if (tick) begin
        div_cnt_ff <= 7'h00;
        if (edge_ff == 4'h0) begin
          smp_ff <= sample_in; // sampling edge
        end
        if (edge_ff == `CONV_LAST_EDGE) begin
          edge_ff <= 4'h0;
          acc_ff <= sum;
          conv_ff <= 6'(conv_ff + 6'h01);
          if (last_conv) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            result_ff <= 10'(sum >> avg_shift(cfg_ff.aux_average_select));
          end
        end else begin
          edge_ff <= 4'(edge_ff + 4'h1);
        end
      end else if (busy_ff) begin
        div_cnt_ff <= 7'(div_cnt_ff + 7'h01);
      end
    end
  end

  AST_ONE_CONV: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && !busy_ff && cfg.aux_clock_divide == 3'h0 && cfg.aux_average_select == 3'h0
    |-> ##13 done_ff) else $error("single conversion not 12 edges");
  AST_AVG_TWO: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && !busy_ff && cfg.aux_clock_divide == 3'h1 && cfg.aux_average_select == 3'h1
    |-> ##49 done_ff) else $error("two-average conversion length wrong");
endmodule
`default_nettype wire

// ### src/afe_ctrl.sv
// afe_ctrl: tx/rx mode control, serial write port, aux DAC codes and
// aux converter readout for a half-duplex converter front end
// assumes cs_n, sclk, din and txrx_pin are asynchronous to ref_clk and
// that the analog cores and the aux converter core sit outside
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_consts.svh"
module afe_ctrl
  import afe_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic txrx_pin,
  output logic dout,
  output logic dout_oe_n,
  input wire logic [9:0] rx_sample,
  input wire logic [9:0] bus_in,
  output logic [9:0] bus_out,
  output logic bus_oe_n,
  output logic [9:0] tx_word,
  output logic rx_core_on,
  output logic tx_core_on,
  output logic mode_ready,
  output logic [11:0] freq_control_dac,
  output logic [11:0] gain_control_dac_a,
  output logic [11:0] gain_control_dac_b,
  output logic aux_dac_on,
  input wire logic [9:0] aux_sample,
  output logic aux_sample_take,
  output var aux_ctrl_t aux_ctrl
);
  // recovery counts, rounded down as longest times
  localparam int FAST_CYC = `T_FAST_NS / `REF_CLK_PERIOD_NS;
  localparam int R2T_CYC = `T_SLOW_RX2TX_NS / `REF_CLK_PERIOD_NS;
  localparam int T2R_CYC = `T_SLOW_TX2RX_NS / `REF_CLK_PERIOD_NS;
  localparam int FAST_BOUND = FAST_CYC + 2;

  // pin synchronisers; stage 0 feeds stage 1 only
  logic [2:0] cs_sy, sclk_sy, pin_sy;
  logic [1:0] din_sy;
  logic cs_low, cs_fall, cs_rise, sclk_rise, sclk_fall, pin_edge;

  // serial input
  logic [15:0] shift_ff; // incoming command, msb first
  logic [4:0] bit_cnt_ff; // bits seen, saturates above 16
  logic cmd_latch; // one-cycle pulse at a valid latch
  logic [3:0] cmd_addr;
  logic [11:0] cmd_data;
  logic is_enable;

  // mode control
  txrx_state_t state_ff, nxt_state;
  logic fast_ff, nxt_fast; // fast (both cores on) vs slow
  logic src_spi_ff, nxt_src; // 1: serial control, 0: pin
  logic rec_start; // starts a recovery interval
  logic [11:0] rec_cnt_ff; // cycles left until settled
  logic active; // rx or tx, not low power
  logic [2:0] code;
  logic dir_tx;

  // aux dacs: programmed codes and driven codes
  logic [11:0] freq_ff, gain_a_ff, gain_b_ff;
  logic [11:0] freq_out_ff, gain_a_out_ff, gain_b_out_ff;

  // aux converter control and readout
  aux_ctrl_t aux_ff, aux_wr;
  logic aux_write, aux_go;
  logic seq_busy, seq_done;
  logic [9:0] seq_result;
  dout_state_t do_state_ff;
  logic [9:0] out_sr_ff; // readout shifter
  logic dout_ff, dout_oe_n_ff;

  // bus data registers
  logic [9:0] bus_out_ff, tx_word_ff;

  // two flops before anything looks at a pin
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cs_sy <= 3'h7; // idle deselected
      sclk_sy <= 3'h0;
      pin_sy <= 3'h0;
      din_sy <= 2'h0;
    end else begin
      cs_sy <= {cs_sy[1:0], cs_n};
      sclk_sy <= {sclk_sy[1:0], sclk};
      pin_sy <= {pin_sy[1:0], txrx_pin};
      din_sy <= {din_sy[0], din};
    end
  end

  // edges on synchronised levels; steady idle level gives no edge
  assign cs_low = ~cs_sy[1];
  assign cs_fall = ~cs_sy[1] & cs_sy[2];
  assign cs_rise = cs_sy[1] & ~cs_sy[2];
  assign sclk_rise = sclk_sy[1] & ~sclk_sy[2];
  assign sclk_fall = ~sclk_sy[1] & sclk_sy[2];
  assign pin_edge = pin_sy[1] ^ pin_sy[2];

  // shift in on sclk rise while selected
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
    end else if (cs_fall) begin
      bit_cnt_ff <= 5'h00; // new frame
    end else if (cs_low && sclk_rise) begin
      shift_ff <= {shift_ff[14:0], din_sy[1]};
      if (bit_cnt_ff <= `CMD_BITS) begin
        bit_cnt_ff <= 5'(bit_cnt_ff + 5'h01);
      end
    end
  end

  // short or long frames are dropped, not latched
  assign cmd_latch = cs_rise && (bit_cnt_ff == `CMD_BITS);
  assign cmd_addr = shift_ff[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
  assign cmd_data = shift_ff[`CMD_DATA_MSB:0];
  assign is_enable = cmd_latch &&
    (cmd_addr == `ADDR_ENABLE16 || cmd_addr == `ADDR_ENABLE8);
  assign active = (state_ff == ST_RX) || (state_ff == ST_TX);
  assign code = cmd_data[2:0];
  // with pin control the pin picks the direction even on a command
  assign dir_tx = cmd_data[`SRC_SEL_BIT] ?
    (code == `MODE_SLOW_TX || code == `MODE_FAST_TX) : pin_sy[1];

  // next mode: serial command first, pin edge otherwise
  always_comb begin
    nxt_state = state_ff;
    nxt_fast = fast_ff;
    nxt_src = src_spi_ff;
    rec_start = 1'b0;
    if (is_enable) begin
      nxt_src = cmd_data[`SRC_SEL_BIT];
      rec_start = 1'b1;
      case (code)
        `MODE_SHUTDOWN_STATE: nxt_state = ST_SHUTDOWN_STATE;
        `MODE_IDLE: nxt_state = ST_IDLE;
        `MODE_STANDBY_STATE: nxt_state = ST_STANDBY_STATE;
        default: begin
          nxt_state = dir_tx ? ST_TX : ST_RX;
          nxt_fast = (code >= `MODE_FAST_RX);
        end
      endcase
    end else if (!src_spi_ff && active && pin_edge) begin
      nxt_state = pin_sy[1] ? ST_TX : ST_RX;
      rec_start = 1'b1;
    end
  end

  // mode registers; reset is pin control, fast receive
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_RX;
      fast_ff <= 1'b1;
      src_spi_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      fast_ff <= nxt_fast;
      src_spi_ff <= nxt_src;
    end
  end

  // recovery timer; low-power targets need no settling here
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rec_cnt_ff <= 12'h000;
    end else if (rec_start) begin
      if (nxt_state != ST_RX && nxt_state != ST_TX) begin
        rec_cnt_ff <= 12'h000;
      end else if (nxt_fast) begin
        rec_cnt_ff <= 12'(FAST_CYC);
      end else if (nxt_state == ST_TX) begin
        rec_cnt_ff <= 12'(R2T_CYC);
      end else begin
        rec_cnt_ff <= 12'(T2R_CYC);
      end
    end else if (rec_cnt_ff != 12'h000) begin
      rec_cnt_ff <= 12'(rec_cnt_ff - 12'h001);
    end
  end
  assign mode_ready = active && (rec_cnt_ff == 12'h000);

  // core power and bus direction from the state
  always_comb begin
    rx_core_on = 1'b0;
    tx_core_on = 1'b0;
    unique case (state_ff)
      ST_SHUTDOWN_STATE, ST_IDLE, ST_STANDBY_STATE: begin
        rx_core_on = 1'b0;
        tx_core_on = 1'b0;
      end
      ST_RX: begin
        rx_core_on = 1'b1;
        tx_core_on = fast_ff;
      end
      ST_TX: begin
        rx_core_on = fast_ff;
        tx_core_on = 1'b1;
      end
    endcase
  end
  // receive drives the bus only in rx; the others leave it floating
  assign bus_oe_n = (state_ff != ST_RX);

  // both directions sample on the rising clock edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_out_ff <= 10'h000;
      tx_word_ff <= 10'h000;
    end else begin
      bus_out_ff <= rx_sample;
      if (state_ff == ST_TX) begin
        tx_word_ff <= bus_in;
      end
    end
  end
  assign bus_out = bus_out_ff;
  assign tx_word = tx_word_ff;

  // dac code registers; address 1111 matches nothing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      freq_ff <= `FREQ_DAC_RST;
      gain_a_ff <= `GAIN_DAC_RST;
      gain_b_ff <= `GAIN_DAC_RST;
    end else if (cmd_latch) begin
      if (cmd_addr == `ADDR_FREQ_DAC) begin
        freq_ff <= cmd_data;
      end
      if (cmd_addr == `ADDR_GAIN_DAC_A) begin
        gain_a_ff <= cmd_data;
      end
      if (cmd_addr == `ADDR_GAIN_DAC_B) begin
        gain_b_ff <= cmd_data;
      end
    end
  end

  // shutdown forces zero but keeps the codes for wake-up
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      freq_out_ff <= `FREQ_DAC_RST;
      gain_a_out_ff <= `GAIN_DAC_RST;
      gain_b_out_ff <= `GAIN_DAC_RST;
    end else if (nxt_state == ST_SHUTDOWN_STATE) begin
      freq_out_ff <= 12'h000;
      gain_a_out_ff <= 12'h000;
      gain_b_out_ff <= 12'h000;
    end else begin
      freq_out_ff <= freq_ff;
      gain_a_out_ff <= gain_a_ff;
      gain_b_out_ff <= gain_b_ff;
    end
  end
  assign freq_control_dac = freq_out_ff;
  assign gain_control_dac_a = gain_a_out_ff;
  assign gain_control_dac_b = gain_b_out_ff;
  assign aux_dac_on = (state_ff != ST_SHUTDOWN_STATE);

  // aux control word; start only taken while idle
  assign aux_wr = aux_ctrl_t'(cmd_data[`AUX_FIELD_MSB:0]);
  assign aux_write = cmd_latch && (cmd_addr == `ADDR_AUX_MODE);
  assign aux_go = aux_write && aux_wr.aux_convert_start && !aux_ff.aux_convert_start;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aux_ff <= aux_ctrl_t'(`AUX_CTRL_RST);
    end else begin
      if (aux_write) begin
        aux_ff.aux_ref_select <= aux_wr.aux_ref_select;
        aux_ff.aux_input_select <= aux_wr.aux_input_select;
        aux_ff.aux_average_select <= aux_wr.aux_average_select;
        aux_ff.aux_clock_divide <= aux_wr.aux_clock_divide;
        aux_ff.aux_readout_enable <= aux_wr.aux_readout_enable;
      end
      // set on an accepted start, cleared at completion
      if (aux_go) begin
        aux_ff.aux_convert_start <= 1'b1;
      end else if (seq_done) begin
        aux_ff.aux_convert_start <= 1'b0;
      end
    end
  end
  assign aux_ctrl = aux_ff;

  aux_adc_seq u_seq (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(aux_go),
    .cfg(aux_wr),
    .sample_in(aux_sample),
    .sample_take(aux_sample_take),
    .busy(seq_busy),
    .done(seq_done),
    .result(seq_result)
  );

  // dout: float, busy high, ready low, then shift on request
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      do_state_ff <= DO_FLOAT;
      out_sr_ff <= 10'h000;
    end else if (aux_go) begin
      do_state_ff <= DO_BUSY;
    end else begin
      unique case (do_state_ff)
        DO_FLOAT: do_state_ff <= DO_FLOAT;
        DO_BUSY: begin
          if (seq_done) begin
            do_state_ff <= DO_READY;
            out_sr_ff <= seq_result;
          end
        end
        DO_READY: begin
          if (cs_fall) begin
            do_state_ff <= aux_ff.aux_readout_enable ? DO_SHIFT : DO_FLOAT;
          end
        end
        DO_SHIFT: begin
          if (cs_rise) begin
            do_state_ff <= DO_FLOAT;
          end else if (sclk_fall) begin
            out_sr_ff <= {out_sr_ff[8:0], 1'b0};
          end
        end
      endcase
    end
  end

  // pin drivers from flops; a cycle behind the state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dout_ff <= 1'b0;
      dout_oe_n_ff <= 1'b1;
    end else begin
      dout_oe_n_ff <= (do_state_ff == DO_FLOAT);
      dout_ff <= (do_state_ff == DO_BUSY) ||
                 ((do_state_ff == DO_SHIFT) && out_sr_ff[9]);
    end
  end
  assign dout = dout_ff;
  assign dout_oe_n = dout_oe_n_ff;

  AST_FAST_TX_FLOAT: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_ff == ST_TX && fast_ff |-> bus_oe_n && rx_core_on)
    else $error("fast tx must float bus with rx core on");
  AST_FAST_SWITCH: assert property (@(posedge ref_clk) disable iff (!resetn)
    rec_start && nxt_fast && (nxt_state == ST_TX || nxt_state == ST_RX)
    |-> ##[1:FAST_BOUND] mode_ready) else $error("fast switch too slow");
  AST_SLOW_POWER: assert property (@(posedge ref_clk) disable iff (!resetn)
    !fast_ff |-> !(state_ff == ST_TX && rx_core_on) && !(state_ff == ST_RX && tx_core_on))
    else $error("slow mode left idle core on");
  AST_PIN_IGNORED: assert property (@(posedge ref_clk) disable iff (!resetn)
    !active && !is_enable |=> state_ff == $past(state_ff))
    else $error("low-power state left without command");
  AST_SHORT_FRAME: assert property (@(posedge ref_clk) disable iff (!resetn)
    cs_rise && bit_cnt_ff != `CMD_BITS |=> $stable(src_spi_ff) && $stable(freq_ff)
    && $stable(gain_a_ff) && $stable(aux_ff[10:1]))
    else $error("short frame changed state");
  AST_ONES_WORD: assert property (@(posedge ref_clk) disable iff (!resetn)
    cs_rise && shift_ff == 16'hFFFF |=> $stable(freq_ff) && $stable(aux_ff[10:1])
    && $stable(src_spi_ff)) else $error("all-ones word changed a register");
  AST_SHUTDOWN_STATE_DAC: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_ff == ST_SHUTDOWN_STATE |-> freq_control_dac == 12'h000 && gain_control_dac_a == 12'h000)
    else $error("dac not zero in shutdown");
  AST_BUSY_DOUT: assert property (@(posedge ref_clk) disable iff (!resetn)
    aux_go |-> ##2 (dout && !dout_oe_n)) else $error("dout not high while busy");
  AST_READ_FLOAT: assert property (@(posedge ref_clk) disable iff (!resetn)
    do_state_ff == DO_SHIFT && cs_rise && !aux_go |-> ##2 dout_oe_n)
    else $error("dout not floated after readout");
  AST_START_HELD: assert property (@(posedge ref_clk) disable iff (!resetn)
    seq_busy |-> aux_ff.aux_convert_start)
    else $error("start bit cleared during conversion");
endmodule
`default_nettype wire

// ### sim/bb_host.sv
// bb_host: baseband controller model driving the serial port
// assumes tasks are entered on a falling ref_clk edge (4 ns grid)
`timescale 1ns/1ps
`default_nettype none
module bb_host (
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe_n
);
  // idle: deselected, clock still
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // send top n bits of w msb first; sclk idles at idle
  task automatic write(input logic [15:0] w, input int n, input logic idle);
    #80 sclk = idle;
    #80 cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      #80 sclk = 1'b0;
      din = w[i];
      #80 sclk = 1'b1;
    end
    #80 sclk = idle;
    #80 cs_n = 1'b1;
    // released line must not keep its last level
    din = ~din;
    #20;
  endtask
  // ten result bits msb first with din high; oe flags any drive seen
  task automatic read(output logic [9:0] q, output logic oe);
    oe = 1'b0;
    din = 1'b1;
    #80 cs_n = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      #80 sclk = 1'b1;
      #72 q[i] = dout;
      if (dout_oe_n === 1'b0) oe = 1'b1;
      #8 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    din = 1'b0;
    #20;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_afe_ctrl.sv
// tb_afe_ctrl: self-checking bench for the front-end control block
// assumes bb_host on the serial pins; aux core and bus modelled here
`timescale 1ns/1ps
`default_nettype none
module tb_afe_ctrl;
  import afe_ctrl_pkg::*;
  logic ref_clk, resetn, txrx_pin, cs_n, sclk, din, dout, dout_oe_n, bus_oe_n, oe;
  logic rx_core_on, tx_core_on, mode_ready, aux_dac_on, take;
  logic [9:0] rx_sample, host_word, bus_in, bus_out, tx_word, aux_sample, q;
  logic [11:0] dac_f, dac_a, dac_b;
  aux_ctrl_t aux_ctrl;
  int errors = 0;
  int n_compared = 0;
  int t;
  // shared bus level: device drives it only in rx
  assign bus_in = (bus_oe_n === 1'b0) ? bus_out : host_word;
  afe_ctrl uut (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .din(din),
    .txrx_pin(txrx_pin), .dout(dout), .dout_oe_n(dout_oe_n), .rx_sample(rx_sample),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .tx_word(tx_word),
    .rx_core_on(rx_core_on), .tx_core_on(tx_core_on), .mode_ready(mode_ready),
    .freq_control_dac(dac_f), .gain_control_dac_a(dac_a), .gain_control_dac_b(dac_b),
    .aux_dac_on(aux_dac_on), .aux_sample(aux_sample), .aux_sample_take(take),
    .aux_ctrl(aux_ctrl));
  bb_host host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe_n(dout_oe_n));
  // 250 MHz clock
  initial begin
    ref_clk = 1'b1;
    forever #2 ref_clk = ~ref_clk;
  end
  // aux core: code toggles by 3 per sample, so a mean differs from a sample;
  // it restarts at 0x100 whenever dout is not driven high
  always @(posedge ref_clk) begin
    if (take) begin
      aux_sample <= aux_sample ^ 10'h003;
    end else if (dout_oe_n !== 1'b0 || dout === 1'b0) begin
      aux_sample <= 10'h100;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic pin(input logic v);
    @(negedge ref_clk) txrx_pin = v;
  endtask
  task automatic print_verdict;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one conversion: busy span against 12 x count x divisor, then readout
  task automatic conv(input logic [2:0] a, input logic [2:0] d, input logic ro);
    int n;
    int s;
    n = 12 * (1 << ((a > 3'h5) ? 5 : a)) * (1 << d);
    host.write({4'h9, 1'b0, ro, d, a, 4'h1}, 16, 1'b0);
    t = 0;
    while (dout !== 1'b1 && t < 20) begin
      cyc(1);
      t++;
    end
    check({dout_oe_n, dout}, 2'b01);
    s = 0;
    while (dout !== 1'b0 && s < n + 200) begin
      cyc(1);
      s++;
    end
    check(s >= n - 4 && s <= n + (1 << d) + 4, 1);
    check(aux_ctrl[0], 0);
    host.read(q, oe);
    check(oe, ro);
    if (ro) check(q, (a == 3'h0) ? 10'h100 : 10'h101);
  endtask
  initial begin
    resetn = 1'b0;
    txrx_pin = 1'b0;
    rx_sample = 10'h2A5;
    host_word = 10'h15A;
    cyc(6);
    resetn = 1'b1;
    cyc(4);
    check(dac_f, 12'h6E0);
    check({dac_a, dac_b}, 0);
    check(aux_ctrl, 0);
    check({bus_oe_n, rx_core_on, tx_core_on}, 3'b011);
    check(bus_out, 10'h2A5);
    // fast switching under pin control, both ways
    pin(1'b1);
    cyc(100);
    check({bus_oe_n, rx_core_on, mode_ready}, 3'b110);
    cyc(40);
    check({mode_ready, tx_word}, {1'b1, 10'h15A});
    pin(1'b0);
    cyc(100);
    check({bus_oe_n, tx_core_on, mode_ready}, 3'b010);
    cyc(40);
    check(mode_ready, 1);
    // slow mode, speed by command, direction by pin
    host.write(16'h8004, 16, 1'b1);
    cyc(2100);
    check({rx_core_on, tx_core_on}, 2'b10);
    pin(1'b1);
    cyc(1715);
    check({rx_core_on, tx_core_on, mode_ready}, 3'b010);
    cyc(55);
    check(mode_ready, 1);
    pin(1'b0);
    cyc(1990);
    check({rx_core_on, tx_core_on, mode_ready}, 3'b100);
    cyc(55);
    check(mode_ready, 1);
    // serial control: pin no longer matters
    host.write(16'h800E, 16, 1'b0);
    pin(1'b1);
    pin(1'b0);
    cyc(10);
    check({bus_oe_n, tx_core_on}, 2'b11);
    host.write(16'h2123, 16, 1'b0);
    check(dac_a, 12'h123);
    host.write(16'h2456, 15, 1'b0);
    check(dac_a, 12'h123);
    host.write(16'hFFFF, 16, 1'b0);
    check({aux_ctrl, dac_a}, {11'h000, 12'h123});
    host.write(16'h1ABC, 16, 1'b0);
    host.write(16'h3789, 16, 1'b0);
    check({dac_f, dac_b}, {12'hABC, 12'h789});
    // standby and idle ignore the pin and hold the dac codes
    host.write(16'h8002, 16, 1'b0);
    pin(1'b1);
    cyc(10);
    check({aux_dac_on, rx_core_on, tx_core_on, dac_a}, {3'b100, 12'h123});
    host.write(16'h8001, 16, 1'b0);
    pin(1'b0);
    cyc(10);
    check({aux_dac_on, rx_core_on, tx_core_on, dac_f}, {3'b100, 12'hABC});
    // shutdown ignores the pin; back to pin control by command
    host.write(16'h8000, 16, 1'b0);
    pin(1'b1);
    cyc(10);
    check({aux_dac_on, rx_core_on, tx_core_on, dac_f}, 0);
    host.write(16'h8005, 16, 1'b0);
    check({aux_dac_on, bus_oe_n, dac_a}, {2'b11, 12'h123});
    cyc(140);
    pin(1'b0);
    host.write(16'h900E, 16, 1'b0);
    check(aux_ctrl, 11'h00E);
    for (int a = 0; a < 8; a++) conv(a[2:0], 3'h0, 1'b1);
    for (int d = 1; d < 8; d++) conv(3'h0, d[2:0], 1'b1);
    conv(3'h1, 3'h1, 1'b0);
    print_verdict();
  end
  // watchdog well beyond the expected run
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
